// *** design/adcr_regs.sv ***
// What this block does
// - each finished result goes to last-result bits 9:0 and holds until the next.
// - a channel result register loads only while its channel is enabled, then holds.
// - a one written to interrupt-enable sets that mask bit; zeros do nothing.
// - a one written to interrupt-disable clears that mask bit; zeros do nothing.
// - the mask register reads one for each enabled interrupt source.
// - enable, disable, mask share one layout: done 0-3, overrun 8-11, 16-19 singles.
// - result-ready sets on any finished conversion, clears on a last-result read.
// - channel overrun sets on an unread result replaced, clears on a status read.
// - conversion-done reads one only while enabled and its conversion completed.
`timescale 1ns/10ps
`include "adcr_defines.svh"

module adcr_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [`ADCR_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [`ADCR_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // converter core, same clock
  input wire adcr_pkg::adcr_conv_t conv,
  input wire logic rx_count_done_in,
  input wire logic rx_buffers_full_in,
  // to converter core and interrupt controller
  output logic [`ADCR_NUM_CH-1:0] chan_enable,
  output logic irq
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************
  // write channel
  // ****************************************
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
  logic aw_full_d, w_full_d, awready_d, wready_d, bvalid_d;
  logic [`ADCR_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic aw_take, w_take, do_write;

  assign aw_take = awvalid && awready_q;
  assign w_take = wvalid && wready_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;

  // address and data may land in either order; the write fires once both are held
  always_comb begin
    aw_full_d = do_write ? 1'b0 : (aw_full_q || aw_take);
    w_full_d = do_write ? 1'b0 : (w_full_q || w_take);
    bvalid_d = do_write || (bvalid_q && !bready);
    awready_d = !aw_full_d && !bvalid_d;
    wready_d = !w_full_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= {awaddr[`ADCR_ADDR_W-1:2], 2'h0};
      end
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  logic [31:0] wval;
  logic wr_chen, wr_chdis, wr_status, wr_ien, wr_idis, wr_known, wr_ro;
  adcr_pkg::adcr_irq_bits_t w1_bits;

  assign wval = w_data_q & {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign w1_bits = adcr_pkg::adcr_irq_bits_t'(wval & `ADCR_IRQ_VALID);
  assign wr_chen = do_write && aw_addr_q == `ADCR_OFF_CHAN_EN;
  assign wr_chdis = do_write && aw_addr_q == `ADCR_OFF_CHAN_DIS;
  assign wr_status = do_write && aw_addr_q == `ADCR_OFF_STATUS;
  assign wr_ien = do_write && aw_addr_q == `ADCR_OFF_IRQ_EN;
  assign wr_idis = do_write && aw_addr_q == `ADCR_OFF_IRQ_DIS;
  // read-only registers take writes silently
  assign wr_ro = aw_addr_q == `ADCR_OFF_CHAN_STAT || aw_addr_q == `ADCR_OFF_LAST ||
                 aw_addr_q == `ADCR_OFF_IRQ_MASK ||
                 (aw_addr_q & `ADCR_CHAN_RES_MASK) == `ADCR_OFF_CHAN_RES;
  assign wr_known = wr_ro || aw_addr_q == `ADCR_OFF_CHAN_EN || aw_addr_q == `ADCR_OFF_CHAN_DIS ||
                    aw_addr_q == `ADCR_OFF_STATUS || aw_addr_q == `ADCR_OFF_IRQ_EN ||
                    aw_addr_q == `ADCR_OFF_IRQ_DIS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_q <= `ADCR_RESP_OKAY;
    end else if (do_write) begin
      bresp_q <= wr_known ? `ADCR_RESP_OKAY : `ADCR_RESP_SLVERR;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic ar_take, arready_q, rvalid_q, rvalid_d;
  logic [`ADCR_ADDR_W-1:0] ar_word;
  logic [31:0] rdata_q, rd_val;
  logic [1:0] rresp_q;
  logic rd_ok, rd_last, rd_status, chan_hit;
  logic [`ADCR_NUM_CH-1:0] rd_chan;

  assign ar_take = arvalid && arready_q;
  assign ar_word = {araddr[`ADCR_ADDR_W-1:2], 2'h0};
  assign rvalid_d = ar_take || (rvalid_q && !rready);
  assign rd_last = ar_take && ar_word == `ADCR_OFF_LAST;
  assign rd_status = ar_take && ar_word == `ADCR_OFF_STATUS;
  assign chan_hit = (ar_word & `ADCR_CHAN_RES_MASK) == `ADCR_OFF_CHAN_RES;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ****************************************
  // converter state
  // ****************************************
  logic [`ADCR_NUM_CH-1:0] chen_q, done_v, ovr_v;
  adcr_pkg::adcr_data_t last_q;
  adcr_pkg::adcr_data_t chan_data [`ADCR_NUM_CH];
  adcr_pkg::adcr_irq_bits_t mask_q, status_v;
  logic rdy_q, govr_q, rxcd_q, rxbf_q, irq_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chen_q <= `ADCR_RST_CHAN_EN;
    end else if (wr_chen) begin
      chen_q <= chen_q | wval[`ADCR_NUM_CH-1:0];
    end else if (wr_chdis) begin
      chen_q <= chen_q & ~wval[`ADCR_NUM_CH-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_q <= '0;
    end else if (conv.valid) begin
      last_q <= conv.data;
    end
  end

  // a fresh result wins over a same-cycle read of the last result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_q <= 1'b0;
    end else if (conv.valid) begin
      rdy_q <= 1'b1;
    end else if (rd_last || (wr_status && w1_bits.result_ready)) begin
      rdy_q <= 1'b0;
    end
  end

  // general overrun: last result replaced before anyone read it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      govr_q <= 1'b0;
    end else if (conv.valid && rdy_q) begin
      govr_q <= 1'b1;
    end else if (rd_status || (wr_status && w1_bits.any_overrun)) begin
      govr_q <= 1'b0;
    end
  end

  // receive-transfer levels are owned by the transfer counters elsewhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxcd_q <= 1'b0;
      rxbf_q <= 1'b0;
    end else begin
      rxcd_q <= rx_count_done_in;
      rxbf_q <= rx_buffers_full_in;
    end
  end

  for (genvar i = 0; i < `ADCR_NUM_CH; i++) begin : g_chan
    assign rd_chan[i] = ar_take && ar_word == 8'(`ADCR_OFF_CHAN_RES + `ADCR_CHAN_STRIDE * i);
    adcr_slot #(.DATA_W(`ADCR_DATA_W)) u_slot (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(conv.valid && conv.chan == 2'(i) && chen_q[i]),
      .data(conv.data),
      .enabled(chen_q[i]),
      .res_read(rd_chan[i]),
      .status_read(rd_status),
      .done_w1c(wr_status && w1_bits.conv_done[i]),
      .ovr_w1c(wr_status && w1_bits.chan_overrun[i]),
      .data_q(chan_data[i]),
      .done_q(done_v[i]),
      .ovr_q(ovr_v[i])
    );
  end

  // ****************************************
  // interrupt mask and status view
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= adcr_pkg::adcr_irq_bits_t'(`ADCR_RST_MASK);
    end else if (wr_ien) begin
      mask_q <= mask_q | w1_bits;
    end else if (wr_idis) begin
      mask_q <= mask_q & ~w1_bits;
    end
  end

  always_comb begin
    status_v = '0;
    status_v.conv_done = done_v & chen_q;
    status_v.chan_overrun = ovr_v;
    status_v.result_ready = rdy_q;
    status_v.any_overrun = govr_q;
    status_v.rx_count_done = rxcd_q;
    status_v.rx_buffers_full = rxbf_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_v & mask_q);
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // write-only registers read as zero with an okay answer
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    if (chan_hit) begin
      rd_val = 32'(chan_data[ar_word[3:2]]);
    end else begin
      case (ar_word)
        `ADCR_OFF_CHAN_STAT: rd_val = 32'(chen_q);
        `ADCR_OFF_STATUS: rd_val = status_v;
        `ADCR_OFF_LAST: rd_val = 32'(last_q);
        `ADCR_OFF_IRQ_MASK: rd_val = mask_q;
        `ADCR_OFF_CHAN_EN, `ADCR_OFF_CHAN_DIS, `ADCR_OFF_IRQ_EN, `ADCR_OFF_IRQ_DIS: rd_val = '0;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= '0;
      rresp_q <= `ADCR_RESP_OKAY;
    end else if (ar_take) begin
      rdata_q <= rd_val;
      rresp_q <= rd_ok ? `ADCR_RESP_OKAY : `ADCR_RESP_SLVERR;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign chan_enable = chen_q;
  assign irq = irq_q;

  // ****************************************
  // checks
  // ****************************************
  sequence wr_taken_s;
    aw_full_q && w_full_q && !bvalid_q;
  endsequence
  sequence wr_answered_s;
    ##1 bvalid_q;
  endsequence
  sequence ien_write_s;
    wr_ien ##1 1'b1;
  endsequence

  last_capture_a: assert property (conv.valid |=> last_q == $past(conv.data)) else $error("last result not captured");
  last_stable_a: assert property (!conv.valid |=> $stable(last_q)) else $error("last result moved without conversion");
  ien_sets_a: assert property (ien_write_s |-> (mask_q & $past(w1_bits)) == $past(w1_bits))
    else $error("enable write did not set mask");
  ien_keeps_a: assert property (wr_ien |=> (mask_q | ~$past(mask_q)) == '1) else $error("enable write cleared a mask bit");
  idis_clears_a: assert property (wr_idis |=> (mask_q & $past(w1_bits)) == '0)
    else $error("disable write left mask bit set");
  idis_keeps_a: assert property (wr_idis |=> (mask_q & ~$past(w1_bits)) == ($past(mask_q) & ~$past(w1_bits)))
    else $error("disable write touched other bits");
  mask_read_a: assert property (ar_take && ar_word == `ADCR_OFF_IRQ_MASK && !wr_ien && !wr_idis
    |=> rdata_q == mask_q) else $error("mask read wrong");
  layout_a: assert property ((mask_q & ~`ADCR_IRQ_VALID) == '0) else $error("mask bit outside layout");
  irq_level_a: assert property (|(status_v & mask_q) |=> irq_q) else $error("interrupt not raised");
  irq_drop_a: assert property (!(|(status_v & mask_q)) |=> !irq_q) else $error("interrupt not dropped");
  rdy_set_a: assert property (conv.valid |=> rdy_q [*1] ##0 status_v.result_ready) else $error("result ready not set");
  rdy_clear_a: assert property (rd_last && !conv.valid |=> !rdy_q) else $error("result ready not cleared by read");
  ovr_clear_a: assert property (rd_status && !conv.valid |=> ovr_v == '0) else $error("overrun survived status read");
  done_off_a: assert property (!conv.valid |=> (status_v.conv_done & ~$past(status_v.conv_done)) == '0)
    else $error("done bit rose without a conversion");
  wr_resp_a: assert property (wr_taken_s |-> wr_answered_s) else $error("write answer not one cycle after pairing");

endmodule : adcr_regs

// *** design/adcr_slot.sv ***
`timescale 1ns/10ps
`include "adcr_defines.svh"

module adcr_slot #(
  parameter int DATA_W = `ADCR_DATA_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // capture side
  input wire logic load,
  input wire logic [DATA_W-1:0] data,
  input wire logic enabled,
  // software side
  input wire logic res_read,
  input wire logic status_read,
  input wire logic done_w1c,
  input wire logic ovr_w1c,
  // held state
  output logic [DATA_W-1:0] data_q,
  output logic done_q,
  output logic ovr_q
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= '0;
    end else if (load) begin
      data_q <= data;
    end
  end

  // a done flag means nothing once the channel is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (load) begin
      done_q <= 1'b1;
    end else if (res_read || done_w1c || !enabled) begin
      done_q <= 1'b0;
    end
  end

  // set wins over a status read in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_q <= 1'b0;
    end else if (load && done_q) begin
      ovr_q <= 1'b1;
    end else if (status_read || ovr_w1c) begin
      ovr_q <= 1'b0;
    end
  end

  slot_hold_a: assert property (!load |=> $stable(data_q)) else $error("channel result moved without load");
  slot_ovr_a: assert property (load && done_q |=> ovr_q) else $error("unread result overwritten, no overrun");
  slot_done_a: assert property (!enabled |-> ##1 (!done_q || $past(load))) else $error("done set on off channel");

endmodule : adcr_slot

// *** dv/adcr_regs_bench.sv ***
`timescale 1ns/10ps
`include "adcr_defines.svh"

module adcr_regs_bench;
  // ****************************************
  // clock, reset and design
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] chan_enable;
  adcr_pkg::adcr_conv_t conv = '0;
  logic rx_cnt = 1'b0, rx_full = 1'b0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int miscompares = 0, num_checks = 0, cycles = 0;
  logic [31:0] lfsr_q = 32'h5ddf1384;
  logic [31:0] m, r;
  logic [9:0] d0, d1, d2;

  initial begin
    forever #4 aclk = ~aclk;
  end

  adcr_regs u_adcr_regs (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .conv(conv), .rx_count_done_in(rx_cnt),
    .rx_buffers_full_in(rx_full), .chan_enable(chan_enable), .irq(irq));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // write address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
                    input logic [3:0] s = 4'hf);
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    rq.push_back({er, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // one-cycle pulse, then results settle
  task automatic cv(input logic [1:0] ch, input logic [9:0] d);
    conv <= '{1'b1, ch, d};
    @(posedge aclk);
    conv <= '0;
    repeat (3) @(posedge aclk);
  endtask : cv

  // ****************************************
  // response monitor
  // ****************************************
  always @(posedge aclk) begin
    logic [33:0] e;
    if (rvalid && rready) begin
      e = rq.pop_front();
      chk({30'h0, rresp}, {30'h0, e[33:32]});
      chk(rdata, e[31:0]);
    end
    if (bvalid && bready) chk({30'h0, bresp}, {30'h0, bq.pop_front()});
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`ADCR_OFF_IRQ_MASK, 32'h0);
    rd(`ADCR_OFF_IRQ_EN, 32'h0);
    rd(8'h40, 32'h0, `ADCR_RESP_SLVERR);
    wr(8'h04, 32'hffffffff, `ADCR_RESP_SLVERR);
    rd(`ADCR_OFF_IRQ_MASK, 32'h0);
    $display("test reset done");
    // walk every bit: only the documented sources may stick
    m = 32'h0;
    for (int i = 0; i < 32; i++) begin
      wr(`ADCR_OFF_IRQ_EN, 32'h1 << i);
      m |= (32'h1 << i) & 32'h000f0f0f;
      rd(`ADCR_OFF_IRQ_MASK, m);
    end
    wr(`ADCR_OFF_IRQ_DIS, 32'hffffffff);
    rd(`ADCR_OFF_IRQ_MASK, 32'h0);
    // only byte 2 strobed: the single-bit sources alone may stick
    wr(`ADCR_OFF_IRQ_EN, 32'hffffffff, 2'h0, 4'h4);
    rd(`ADCR_OFF_IRQ_MASK, 32'h000f0000);
    wr(`ADCR_OFF_IRQ_DIS, 32'hffffffff);
    r = rnd();
    wr(`ADCR_OFF_IRQ_EN, r);
    m = r & 32'h000f0f0f;
    wr(`ADCR_OFF_IRQ_EN, 32'h0);
    rd(`ADCR_OFF_IRQ_MASK, m);
    r = rnd();
    wr(`ADCR_OFF_IRQ_DIS, r);
    m &= ~r;
    rd(`ADCR_OFF_IRQ_MASK, m);
    wr(`ADCR_OFF_IRQ_DIS, 32'hffffffff);
    $display("test mask done");
    wr(`ADCR_OFF_CHAN_EN, 32'h3);
    chk({28'h0, chan_enable}, 32'h3);
    r = rnd();
    d0 = r[9:0];
    d1 = r[19:10];
    d2 = r[29:20];
    cv(2'h0, d0);
    rd(`ADCR_OFF_STATUS, 32'h00010001);
    rd(`ADCR_OFF_LAST, {22'h0, d0});
    cv(2'h0, d1);
    cv(2'h2, d2);
    rd(`ADCR_OFF_STATUS, 32'h00030101);
    rd(`ADCR_OFF_STATUS, 32'h00010001);
    rd(`ADCR_OFF_CHAN_RES, {22'h0, d1});
    rd(`ADCR_OFF_CHAN_RES + 8'h08, 32'h0);
    rd(`ADCR_OFF_STATUS, 32'h00010000);
    rd(`ADCR_OFF_LAST, {22'h0, d2});
    rd(`ADCR_OFF_LAST, {22'h0, d2});
    rd(`ADCR_OFF_STATUS, 32'h0);
    cv(2'h1, d0);
    wr(`ADCR_OFF_CHAN_DIS, 32'h2);
    rd(`ADCR_OFF_STATUS, 32'h00010000);
    rd(`ADCR_OFF_LAST, {22'h0, d0});
    rx_cnt <= 1'b1;
    rx_full <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`ADCR_OFF_STATUS, 32'h000c0000);
    rx_cnt <= 1'b0;
    rx_full <= 1'b0;
    $display("test results done");
    wr(`ADCR_OFF_IRQ_EN, 32'h00010000);
    chk({31'h0, irq}, 32'h0);
    cv(2'h0, d1);
    chk({31'h0, irq}, 32'h1);
    rd(`ADCR_OFF_LAST, {22'h0, d1});
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(`ADCR_OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    // done flag cleared by a one written to status drops the line
    wr(`ADCR_OFF_STATUS, 32'h1);
    rd(`ADCR_OFF_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    cv(2'h0, d2);
    chk({31'h0, irq}, 32'h1);
    wr(`ADCR_OFF_IRQ_DIS, 32'h00010001);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
    complete_run();
  end
endmodule : adcr_regs_bench

// *** pkg/adcr_defines.svh ***
`ifndef ADCR_DEFINES_SVH
`define ADCR_DEFINES_SVH

// ****************************************
// bus geometry
// ****************************************
`define ADCR_ADDR_W 8
`define ADCR_NUM_CH 4
`define ADCR_DATA_W 10

// ****************************************
// register byte offsets
// ****************************************
`define ADCR_OFF_CHAN_EN 8'h10
`define ADCR_OFF_CHAN_DIS 8'h14
`define ADCR_OFF_CHAN_STAT 8'h18
`define ADCR_OFF_STATUS 8'h1c
`define ADCR_OFF_LAST 8'h20
`define ADCR_OFF_IRQ_EN 8'h24
`define ADCR_OFF_IRQ_DIS 8'h28
`define ADCR_OFF_IRQ_MASK 8'h2c
`define ADCR_OFF_CHAN_RES 8'h30
`define ADCR_CHAN_RES_MASK 8'hf0
`define ADCR_CHAN_STRIDE 8'h04

// ****************************************
// field layout and reset values
// ****************************************
`define ADCR_IRQ_VALID 32'h000f0f0f
`define ADCR_RST_MASK 32'h00000000
`define ADCR_RST_CHAN_EN 4'h0

// ****************************************
// bus answers
// ****************************************
`define ADCR_RESP_OKAY 2'h0
`define ADCR_RESP_SLVERR 2'h2

`endif

// *** pkg/adcr_pkg.sv ***
`include "adcr_defines.svh"

package adcr_pkg;

  typedef logic [`ADCR_DATA_W-1:0] adcr_data_t;

  // one finished conversion from the converter core
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    adcr_data_t data;
  } adcr_conv_t;

  // shared layout of status, enable, disable and mask
  typedef struct packed {
    logic [11:0] rsv_hi;
    logic rx_buffers_full;
    logic rx_count_done;
    logic any_overrun;
    logic result_ready;
    logic [3:0] rsv_b;
    logic [3:0] chan_overrun;
    logic [3:0] rsv_a;
    logic [3:0] conv_done;
  } adcr_irq_bits_t;

endpackage : adcr_pkg
